// File: logic/adc_conversion_sequencer.sv
// Conversion sequencer: AHB-Lite registers, prescaler, start logic and core control
//
// What this block does
// - Writing one to start begins conversion; start reads one while converting.
// - Single mode: hardware clears start when the conversion completes.
// - New channel written mid-conversion applies only after current conversion ends.
// - Completion sets result-ready and requests interrupt if both enables set.
// - Result-ready is set on completion even with its interrupt disabled.
// - With event start enabled, each routed event arriving while idle triggers a conversion.
// - Event input is edge detected, sets start, cleared at completion in single mode.
// - Continuous mode restarts right after each completion until zero is written to start.
// - Prescaler divides clock by selected factor; held at zero when disabled.
// - Prescaler held reset when idle; start waits half factor plus two cycles.
// - Plain conversion lasts exactly 13 converter-clock cycles.
// - Sample-and-hold happens two plus delay plus length converter cycles after conversion start.
// - Result-ready clears on result read or on writing one to it.
// - Sampling window lasts two plus sample delay plus sample length.
// - Continuous starts spaced 13 plus delay plus length converter cycles.
// - Selections go via shadow; active follows shadow until conversion starts.
// - Active selection frozen during conversion, updates again in last cycle.
// - Continuous mode: channel write mid-conversion affects conversion after next.
// - Input above reference gives full-scale code; result saturates at maximum.
// - Ten-bit result is presented right-adjusted in the result register.
// - Channel and reference selections take no effect while converter disabled.
`timescale 1ns/1ns
module adc_conversion_sequencer (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Event router and interrupt controller
  input wire logic event_trigger,
  input wire logic global_int_enable,
  output logic result_ready_irq,
  output logic result_ready_event,
  // Converter core
  output adc_seq_pkg::core_ctrl_s core_ctrl,
  input wire adc_seq_pkg::core_status_s core_status
);
  import adc_seq_pkg::*;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Last count of a full prescaler period: factor is 2 << select
  function automatic logic [PRESCALE_W-1:0] period_last(input logic [DIVIDER_W-1:0] sel);
    logic [PRESCALE_W:0] factor;
    factor = 9'h002 << sel;
    return PRESCALE_W'(factor - 9'h001);
  endfunction : period_last

  // Count at which the converter clock rises: half the factor minus one
  function automatic logic [PRESCALE_W-1:0] half_last(input logic [DIVIDER_W-1:0] sel);
    logic [PRESCALE_W:0] half;
    half = 9'h001 << sel;
    return PRESCALE_W'(half - 9'h001);
  endfunction : half_last

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] rd_word;
  logic addr_phase;
  logic wr_en;
  logic rd_result;
  logic enable_reg;
  logic continuous_mode_bit_reg;
  logic [CHANNEL_W-1:0] positive_input_select_reg;
  logic [REFERENCE_W-1:0] reference_select_reg;
  logic [DIVIDER_W-1:0] clock_divider_select_reg;
  logic [DELAY_W-1:0] sample_delay_reg;
  logic [LENGTH_W-1:0] sample_length_reg;
  logic event_start_enable_reg;
  logic result_ready_ie_reg;
  logic result_ready_flag_reg;
  logic [RESULT_W-1:0] conversion_result_reg;
  logic start_conversion_bit_reg;
  logic stop_request_reg;
  logic ev_meta_reg;
  logic ev_sync_reg;
  logic ev_last_reg;
  logic ev_edge;
  logic trigger;
  seq_state_e state_reg;
  logic [PRESCALE_W-1:0] clock_divider_select_cnt_reg;
  logic tick_reg;
  logic clock_divider_select_run;
  logic [CYCLE_W-1:0] cycle_reg;
  logic [CYCLE_W-1:0] total_last;
  logic [CYCLE_W-1:0] window_len;
  logic last_cycle;
  logic complete;
  logic keep_running;
  logic conv_begin;
  logic locked;
  logic [CHANNEL_W-1:0] snap_channel_reg;
  logic [REFERENCE_W-1:0] snap_reference_reg;

  // ----------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ----------------------------------------------------------------
  assign addr_phase = hsel && hready && htrans[1];
  assign wr_en = wr_pend_reg;
  assign rd_result = addr_phase && !hwrite && (haddr[7:0] == OFS_RESULT);

  always_comb begin
    rd_word = 32'h0000_0000;
    case (haddr[7:0])
      OFS_CTRL: begin
        rd_word[ENABLE_POS] = enable_reg;
        rd_word[CONTINUOUS_POS] = continuous_mode_bit_reg;
      end
      OFS_COMMAND: rd_word[START_POS] = start_conversion_bit_reg;
      OFS_CHANNEL: rd_word[CHANNEL_LSB +: CHANNEL_W] = positive_input_select_reg;
      OFS_CLKREF: begin
        rd_word[REFERENCE_LSB +: REFERENCE_W] = reference_select_reg;
        rd_word[DIVIDER_LSB +: DIVIDER_W] = clock_divider_select_reg;
      end
      OFS_SAMPLE: begin
        rd_word[DELAY_LSB +: DELAY_W] = sample_delay_reg;
        rd_word[LENGTH_LSB +: LENGTH_W] = sample_length_reg;
      end
      OFS_EVENT: rd_word[EVENT_START_POS] = event_start_enable_reg;
      OFS_INT_ENABLE: rd_word[READY_POS] = result_ready_ie_reg;
      OFS_INT_FLAG: rd_word[READY_POS] = result_ready_flag_reg;
      OFS_RESULT: rd_word[RESULT_W-1:0] = conversion_result_reg;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_reg <= addr_phase && hwrite;
      if (addr_phase) begin
        wr_addr_reg <= haddr[7:0];
        hrdata <= hwrite ? 32'h0000_0000 : rd_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_reg <= 1'b0;
      continuous_mode_bit_reg <= 1'b0;
      positive_input_select_reg <= CHANNEL_RESET;
      reference_select_reg <= REFERENCE_RESET;
      clock_divider_select_reg <= DIVIDER_RESET;
      sample_delay_reg <= DELAY_RESET;
      sample_length_reg <= LENGTH_RESET;
      event_start_enable_reg <= 1'b0;
      result_ready_ie_reg <= 1'b0;
    end else if (wr_en) begin
      case (wr_addr_reg)
        OFS_CTRL: begin
          enable_reg <= hwdata[ENABLE_POS];
          continuous_mode_bit_reg <= hwdata[CONTINUOUS_POS];
        end
        OFS_CHANNEL: positive_input_select_reg <= hwdata[CHANNEL_LSB +: CHANNEL_W];
        OFS_CLKREF: begin
          reference_select_reg <= hwdata[REFERENCE_LSB +: REFERENCE_W];
          clock_divider_select_reg <= hwdata[DIVIDER_LSB +: DIVIDER_W];
        end
        OFS_SAMPLE: begin
          sample_delay_reg <= hwdata[DELAY_LSB +: DELAY_W];
          sample_length_reg <= hwdata[LENGTH_LSB +: LENGTH_W];
        end
        OFS_EVENT: event_start_enable_reg <= hwdata[EVENT_START_POS];
        OFS_INT_ENABLE: result_ready_ie_reg <= hwdata[READY_POS];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Event input: synchroniser and rising-edge detect
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ev_meta_reg <= 1'b0;
      ev_sync_reg <= 1'b0;
      ev_last_reg <= 1'b0;
    end else begin
      ev_meta_reg <= event_trigger;
      ev_sync_reg <= ev_meta_reg;
      ev_last_reg <= ev_sync_reg;
    end
  end

  assign ev_edge = ev_sync_reg && !ev_last_reg;

  // Triggers only count when idle, so nothing can restart a running conversion
  assign trigger = enable_reg && (state_reg == ST_IDLE) &&
                   ((wr_en && (wr_addr_reg == OFS_COMMAND) && hwdata[START_POS]) ||
                    (event_start_enable_reg && ev_edge));

  // ----------------------------------------------------------------
  // Cycle arithmetic
  // ----------------------------------------------------------------
  assign total_last = CONVERSION_CYCLES - 7'd1 + CYCLE_W'(sample_delay_reg) +
                      CYCLE_W'(sample_length_reg);
  assign window_len = SAMPLE_BASE_CYCLES + CYCLE_W'(sample_delay_reg) +
                      CYCLE_W'(sample_length_reg);
  assign last_cycle = (state_reg == ST_CONVERT) && (cycle_reg == total_last);
  assign complete = last_cycle && tick_reg;
  assign keep_running = continuous_mode_bit_reg && !stop_request_reg;
  assign conv_begin = ((state_reg == ST_WAIT_EDGE) && tick_reg) || (complete && keep_running);
  assign locked = (state_reg == ST_CONVERT) && !last_cycle;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  // Running only while not idle keeps the start delay fixed
  assign clock_divider_select_run = enable_reg && (state_reg != ST_IDLE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_divider_select_cnt_reg <= 8'h00;
      tick_reg <= 1'b0;
    end else begin
      if (!clock_divider_select_run) begin
        clock_divider_select_cnt_reg <= 8'h00;
      end else if (clock_divider_select_cnt_reg == period_last(clock_divider_select_reg)) begin
        clock_divider_select_cnt_reg <= 8'h00;
      end else begin
        clock_divider_select_cnt_reg <= clock_divider_select_cnt_reg + 8'h01;
      end
      tick_reg <= clock_divider_select_run && (clock_divider_select_cnt_reg == half_last(clock_divider_select_reg));
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_IDLE;
      cycle_reg <= 7'd0;
    end else if (!enable_reg) begin
      state_reg <= ST_IDLE;
      cycle_reg <= 7'd0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          cycle_reg <= 7'd0;
          if (trigger) begin
            state_reg <= ST_WAIT_EDGE;
          end
        end
        ST_WAIT_EDGE: begin
          if (tick_reg) begin
            state_reg <= ST_CONVERT;
            cycle_reg <= 7'd0;
          end
        end
        ST_CONVERT: begin
          if (complete) begin
            cycle_reg <= 7'd0;
            if (!keep_running) begin
              state_reg <= ST_IDLE;
            end
          end else if (tick_reg) begin
            cycle_reg <= cycle_reg + 7'd1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          cycle_reg <= 7'd0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Start bit and stop request
  // ----------------------------------------------------------------
  // Writing zero cannot drop the bit mid-conversion; it only ends continuous runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_conversion_bit_reg <= 1'b0;
      stop_request_reg <= 1'b0;
    end else begin
      if (!enable_reg) begin
        start_conversion_bit_reg <= 1'b0;
      end else if (trigger) begin
        start_conversion_bit_reg <= 1'b1;
      end else if (complete && !keep_running) begin
        start_conversion_bit_reg <= 1'b0;
      end
      if (state_reg == ST_IDLE) begin
        stop_request_reg <= 1'b0;
      end else if (wr_en && (wr_addr_reg == OFS_COMMAND) && !hwdata[START_POS]) begin
        stop_request_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Result, flag, event and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conversion_result_reg <= RESULT_RESET;
      result_ready_flag_reg <= 1'b0;
      result_ready_event <= 1'b0;
      result_ready_irq <= 1'b0;
    end else begin
      if (complete) begin
        conversion_result_reg <= core_status.over_range ? RESULT_FULL_SCALE :
                                 core_status.data;
      end
      // Completion beats a clear in the same cycle
      if (complete) begin
        result_ready_flag_reg <= 1'b1;
      end else if (rd_result ||
                   (wr_en && (wr_addr_reg == OFS_INT_FLAG) && hwdata[READY_POS])) begin
        result_ready_flag_reg <= 1'b0;
      end
      result_ready_event <= complete;
      result_ready_irq <= result_ready_flag_reg && result_ready_ie_reg &&
                          global_int_enable;
    end
  end

  // ----------------------------------------------------------------
  // Selection snapshot for continuous runs
  // ----------------------------------------------------------------
  // Held from each start, so a change lands two conversions later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      snap_channel_reg <= CHANNEL_RESET;
      snap_reference_reg <= REFERENCE_RESET;
    end else if (conv_begin) begin
      snap_channel_reg <= positive_input_select_reg;
      snap_reference_reg <= reference_select_reg;
    end
  end

  // ----------------------------------------------------------------
  // Converter core drive
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_ctrl <= '0;
    end else begin
      if (enable_reg && !locked) begin
        if (continuous_mode_bit_reg && (state_reg == ST_CONVERT)) begin
          core_ctrl.channel <= snap_channel_reg;
          core_ctrl.reference <= snap_reference_reg;
        end else begin
          core_ctrl.channel <= positive_input_select_reg;
          core_ctrl.reference <= reference_select_reg;
        end
      end
      // Drops at the completion edge so busy spans exactly the conversion
      core_ctrl.converting <= ((state_reg == ST_CONVERT) && !(complete && !keep_running)) ||
                              conv_begin;
      core_ctrl.sample_window <= conv_begin ||
                                 ((state_reg == ST_CONVERT) && !complete &&
                                  ((cycle_reg + 7'd1 < window_len) ||
                                   (!tick_reg && (cycle_reg < window_len))));
      core_ctrl.sample_hold <= (state_reg == ST_CONVERT) && tick_reg &&
                               (cycle_reg == window_len - 7'd1);
      core_ctrl.converter_clock <= clock_divider_select_run &&
                                   (clock_divider_select_cnt_reg >= half_last(clock_divider_select_reg));
    end
  end

endmodule : adc_conversion_sequencer

// File: shared/adc_seq_pkg.sv
// Shared constants, register map and carrier types for the conversion sequencer
package adc_seq_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COMMAND = 8'h04;
  localparam logic [7:0] OFS_CHANNEL = 8'h08;
  localparam logic [7:0] OFS_CLKREF = 8'h0C;
  localparam logic [7:0] OFS_SAMPLE = 8'h10;
  localparam logic [7:0] OFS_EVENT = 8'h14;
  localparam logic [7:0] OFS_INT_ENABLE = 8'h18;
  localparam logic [7:0] OFS_INT_FLAG = 8'h1C;
  localparam logic [7:0] OFS_RESULT = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ENABLE_POS = 0;
  localparam int CONTINUOUS_POS = 1;
  localparam int START_POS = 0;
  localparam int CHANNEL_LSB = 0;
  localparam int REFERENCE_LSB = 0;
  localparam int DIVIDER_LSB = 8;
  localparam int DELAY_LSB = 0;
  localparam int LENGTH_LSB = 8;
  localparam int EVENT_START_POS = 0;
  localparam int READY_POS = 0;

  // ----------------------------------------------------------------
  // Field widths and reset values
  // ----------------------------------------------------------------
  localparam int CHANNEL_W = 5;
  localparam int REFERENCE_W = 3;
  localparam int DIVIDER_W = 3;
  localparam int DELAY_W = 4;
  localparam int LENGTH_W = 6;
  localparam int RESULT_W = 10;
  localparam int CYCLE_W = 7;
  localparam int PRESCALE_W = 8;
  localparam logic [CHANNEL_W-1:0] CHANNEL_RESET = 5'h00;
  localparam logic [REFERENCE_W-1:0] REFERENCE_RESET = 3'h0;
  localparam logic [DIVIDER_W-1:0] DIVIDER_RESET = 3'h0;
  localparam logic [DELAY_W-1:0] DELAY_RESET = 4'h0;
  localparam logic [LENGTH_W-1:0] LENGTH_RESET = 6'h00;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 10'h000;
  localparam logic [RESULT_W-1:0] RESULT_FULL_SCALE = 10'h3FF;

  // ----------------------------------------------------------------
  // Timing counts in converter-clock cycles
  // ----------------------------------------------------------------
  localparam logic [CYCLE_W-1:0] CONVERSION_CYCLES = 7'd13;
  localparam logic [CYCLE_W-1:0] SAMPLE_BASE_CYCLES = 7'd2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_EDGE,
    ST_CONVERT
  } seq_state_e;

  typedef struct packed {
    logic [CHANNEL_W-1:0] channel;
    logic [REFERENCE_W-1:0] reference;
    logic converting;
    logic sample_window;
    logic sample_hold;
    logic converter_clock;
  } core_ctrl_s;

  typedef struct packed {
    logic [RESULT_W-1:0] data;
    logic over_range;
  } core_status_s;

endpackage : adc_seq_pkg

// File: test/adc_seq_chk.sv
// Port assertions for the conversion sequencer
`timescale 1ns/1ns
module adc_seq_chk (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Watched ports
  input wire logic global_int_enable,
  input wire logic result_ready_irq,
  input wire logic result_ready_event,
  input wire adc_seq_pkg::core_ctrl_s core_ctrl
);
  import adc_seq_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [11:0] run_cnt;
  // Busy stretch length, saturating so it never wraps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_cnt <= 12'h000;
    end else if (!core_ctrl.converting) begin
      run_cnt <= 12'h000;
    end else if (run_cnt != 12'hFFF) begin
      run_cnt <= run_cnt + 12'h001;
    end
  end
  a_sel_frozen: assert property ($rose(core_ctrl.converting) |=>
    $stable({core_ctrl.channel, core_ctrl.reference})[*8]) else $error("selection moved");
  a_hold_pulse: assert property (core_ctrl.sample_hold |=>
    !core_ctrl.sample_hold) else $error("hold wider than one cycle");
  a_hold_in_conv: assert property (core_ctrl.sample_hold |->
    core_ctrl.converting) else $error("hold outside conversion");
  a_hold_not_early: assert property ($rose(core_ctrl.converting) |->
    (!core_ctrl.sample_hold)[*3]) else $error("hold too early");
  a_window_start: assert property ($rose(core_ctrl.converting) |->
    core_ctrl.sample_window) else $error("window not open at start");
  a_window_in_conv: assert property (core_ctrl.sample_window |->
    core_ctrl.converting) else $error("window outside conversion");
  a_event_pulse: assert property (result_ready_event |=>
    !result_ready_event) else $error("ready event too wide");
  a_event_after_done: assert property (result_ready_event |->
    $past(core_ctrl.converting, 2)) else $error("ready event without conversion");
  a_irq_gated: assert property (!$past(global_int_enable) |->
    !result_ready_irq) else $error("irq with global enable off");
  a_min_length: assert property ($fell(core_ctrl.converting) |->
    run_cnt >= 12'd26) else $error("conversion too short");
  c_start: cover property ($rose(core_ctrl.converting));
  c_hold: cover property (core_ctrl.sample_hold);
  c_irq: cover property (result_ready_irq);
endmodule : adc_seq_chk
bind adc_conversion_sequencer adc_seq_chk adc_seq_chk_i (.hclk(hclk), .hresetn(hresetn),
  .global_int_enable(global_int_enable), .result_ready_irq(result_ready_irq),
  .result_ready_event(result_ready_event), .core_ctrl(core_ctrl));

// File: test/core_model.sv
// Behavioural converter core facing the sequencer
`timescale 1ns/1ns
module core_model (
  // Clock
  input wire logic hclk,
  // Sequencer side
  input wire adc_seq_pkg::core_ctrl_s core_ctrl,
  output adc_seq_pkg::core_status_s core_status
);
  import adc_seq_pkg::*;
  logic [9:0] code;
  logic ovr;
  logic [9:0] held_code = 10'h000;
  logic held_ovr = 1'b0;
  // Channel 31 stands for an input above the reference
  assign ovr = core_ctrl.channel == 5'h1F;
  assign code = ovr ? 10'h155 : {core_ctrl.channel, 5'h0A};
  // Input is taken at the hold pulse; later mux moves must not reach the result
  always @(posedge hclk) begin
    if (core_ctrl.sample_hold) begin
      held_code <= code;
      held_ovr <= ovr;
    end
  end
  // Inverted code outside a conversion, so a stray sample is caught
  assign core_status = {core_ctrl.converting ? held_code : ~held_code, held_ovr};
endmodule : core_model

// File: test/tb_adc_conversion_sequencer.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ns
module tb_adc_conversion_sequencer;
  import adc_seq_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic evt = 1'b0;
  logic gie = 1'b0;
  wire hready;
  logic hresp;
  logic [31:0] hrdata;
  logic irq;
  logic rdy_ev;
  core_ctrl_s ctrl;
  core_status_s stat;
  int bad_count = 0;
  int n_checks = 0;
  int n;
  logic [31:0] q;
  logic [4:0] ch;
  time ev_t[$];
  always #25 hclk = ~hclk;
  adc_conversion_sequencer adc_conversion_sequencer_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .event_trigger(evt), .global_int_enable(gie), .result_ready_irq(irq),
    .result_ready_event(rdy_ev), .core_ctrl(ctrl), .core_status(stat));
  core_model core_model_i (.hclk(hclk), .core_ctrl(ctrl), .core_status(stat));
  always @(negedge hclk) begin
    if (rdy_ev === 1'b1) begin
      ev_t.push_back($time);
    end
  end
  // ------
  // Tasks
  // ------
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask : chk
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr
  task rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(what, exp, q);
    chk("response", 32'h0, hresp);
  endtask : rd
  task wait_idle;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (ctrl.converting === 1'b1 && n < 9000);
    @(posedge hclk);
  endtask : wait_idle
  // Called at the edge that ends the start write
  task run(input int f, input int cyc);
    n = 0;
    while (ctrl.converting !== 1'b1 && n < 900) begin
      @(negedge hclk);
      n++;
    end
    chk("start delay", f / 2 + 2, n);
    wait_idle;
    chk("busy cycles", cyc, n);
  endtask : run
  function automatic logic [9:0] exp_res(input logic [4:0] c);
    return (c == 5'h1F) ? RESULT_FULL_SCALE : {c, 5'h0A};
  endfunction : exp_res
  // ------
  // Tests
  // ------
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd("ctrl reset", OFS_CTRL, 32'h0);
    rd("unmapped", 8'h40, 32'h0);
    wr(OFS_CHANNEL, 32'h6);
    repeat (2) @(negedge hclk);
    chk("channel while off", CHANNEL_RESET, ctrl.channel);
    @(posedge hclk);
    wr(OFS_CTRL, 32'h1);
    repeat (2) @(negedge hclk);
    chk("channel after on", 32'h6, ctrl.channel);
    @(posedge hclk);
    for (int s = 0; s < 8; s++) begin
      ch = (s == 7) ? 5'h1F : 5'(s + 1);
      wr(OFS_CLKREF, (s << 8) | s);
      wr(OFS_SAMPLE, (s << 8) | s);
      wr(OFS_CHANNEL, ch);
      wr(OFS_COMMAND, 32'h1);
      run(2 << s, (13 + 2 * s) * (2 << s));
      chk("active sel", {ch, 3'(s)}, {ctrl.channel, ctrl.reference});
      chk("irq masked", 32'h0, irq);
      rd("flag", OFS_INT_FLAG, 32'h1);
      rd("start after", OFS_COMMAND, 32'h0);
      rd("result", OFS_RESULT, exp_res(ch));
      rd("flag read clear", OFS_INT_FLAG, 32'h0);
    end
    wr(OFS_CLKREF, 32'h0);
    wr(OFS_SAMPLE, 32'h0);
    wr(OFS_CHANNEL, 32'h3);
    wr(OFS_COMMAND, 32'h1);
    rd("busy", OFS_COMMAND, 32'h1);
    wr(OFS_CHANNEL, 32'h9);
    wr(OFS_COMMAND, 32'h1);
    wait_idle;
    chk("restart ignored", 32'd23, n);
    rd("old channel", OFS_RESULT, exp_res(5'h3));
    wr(OFS_COMMAND, 32'h1);
    run(2, 26);
    rd("new channel", OFS_RESULT, exp_res(5'h9));
    wr(OFS_CHANNEL, 32'h4);
    wr(OFS_SAMPLE, 32'h0201);
    wr(OFS_CTRL, 32'h3);
    ev_t.delete();
    wr(OFS_COMMAND, 32'h1);
    repeat (6) @(posedge hclk);
    wr(OFS_CHANNEL, 32'h5);
    for (int k = 0; k < 3; k++) begin
      n = 0;
      while (ev_t.size() <= k && n < 900) begin
        @(negedge hclk);
        n++;
      end
      @(posedge hclk);
      rd("free run result", OFS_RESULT, exp_res(k == 2 ? 5'h5 : 5'h4));
    end
    rd("free run busy", OFS_COMMAND, 32'h1);
    chk("spacing", 32'd32, 32'((ev_t[1] - ev_t[0]) / 50));
    chk("spacing", 32'd32, 32'((ev_t[2] - ev_t[1]) / 50));
    wr(OFS_COMMAND, 32'h0);
    wait_idle;
    rd("stopped", OFS_COMMAND, 32'h0);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_EVENT, 32'h1);
    wr(OFS_INT_ENABLE, 32'h1);
    wr(OFS_INT_FLAG, 32'h1);
    gie <= 1'b1;
    ev_t.delete();
    for (int k = 0; k < 2; k++) begin
      evt <= 1'b1;
      repeat (3) @(posedge hclk);
      evt <= 1'b0;
      repeat (4) @(posedge hclk);
      rd("event start", OFS_COMMAND, 32'h1);
    end
    wait_idle;
    repeat (80) @(posedge hclk);
    chk("one conversion", 32'h1, ev_t.size());
    chk("irq raised", 32'h1, irq);
    rd("event clears start", OFS_COMMAND, 32'h0);
    gie <= 1'b0;
    repeat (2) @(negedge hclk);
    chk("irq global off", 32'h0, irq);
    @(posedge hclk);
    wr(OFS_INT_FLAG, 32'h1);
    rd("flag write clear", OFS_INT_FLAG, 32'h0);
    wr(OFS_EVENT, 32'h0);
    evt <= 1'b1;
    repeat (3) @(posedge hclk);
    evt <= 1'b0;
    repeat (20) @(negedge hclk);
    chk("event disabled", 32'h0, ctrl.converting);
    chk("clock idle", 32'h0, ctrl.converter_clock);
    tally_and_finish;
  end
  initial begin
    #(40000 * 50);
    bad_count++;
    tally_and_finish;
  end
endmodule : tb_adc_conversion_sequencer
